// File: rtl/keypad_pin_interrupt_pkg.sv
// Package for the keypad pin interrupt block: register indexes, field positions,
// reset values and the per-unit configuration carrier.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses of 16 bits.
package keypad_pin_interrupt_pkg;

  localparam int unsigned UNITS  = 2;
  localparam int unsigned PINS   = 8;
  localparam int unsigned ADDR_W = 16;

  // Register indexes; the byte address is four times the index
  localparam logic [13:0] IDX_SC_0     = 14'h003c;
  localparam logic [13:0] IDX_SC_1     = 14'h003d;
  localparam logic [13:0] IDX_PE_0     = 14'h307c;
  localparam logic [13:0] IDX_ES_0     = 14'h307d;
  localparam logic [13:0] IDX_PE_1     = 14'h307e;
  localparam logic [13:0] IDX_ES_1     = 14'h307f;
  localparam logic [13:0] IDX_IRQ_STAT = 14'h3080;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h3081;

  // Status and control field positions
  localparam int unsigned SC_FLAG_BIT = 3;
  localparam int unsigned SC_ACK_BIT  = 2;
  localparam int unsigned SC_IE_BIT   = 1;
  localparam int unsigned SC_MODE_BIT = 0;

  localparam logic [7:0] REG8_RESET   = 8'h00;
  localparam logic [1:0] IRQ2_RESET   = 2'h0;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic [7:0] pin_enable_bits;
    logic [7:0] polarity_select_bits;
    logic       irq_enable;
    logic       detect_mode_select;
    logic       key_event_flag;
  } unit_cfg_t;

  localparam unit_cfg_t UNIT_RESET = '{REG8_RESET, REG8_RESET, 1'b0, 1'b0, 1'b0};

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [13:0] idx);
    return {idx, 2'b00};
  endfunction : byte_addr

endpackage : keypad_pin_interrupt_pkg

// File: rtl/keypad_pin_interrupt.sv
// Two-unit keypad pin interrupt block with an AXI4-Lite register slave.
// Assumes key inputs are synchronous to aclk; ce low freezes every flip-flop.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module keypad_pin_interrupt (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  key_input_pins_0,
  input  wire logic [7:0]  key_input_pins_1,
  output logic [1:0]       irq_request,
  output logic             irq
);

  keypad_pin_interrupt_pkg::unit_cfg_t u [keypad_pin_interrupt_pkg::UNITS];
  logic [7:0]  pins      [keypad_pin_interrupt_pkg::UNITS];
  logic [7:0]  prev      [keypad_pin_interrupt_pkg::UNITS];
  logic [7:0]  asrt      [keypad_pin_interrupt_pkg::UNITS];
  logic [1:0]  edge_hit;
  logic [1:0]  det;
  logic [1:0]  armed;
  logic [1:0]  sc_wr;
  logic [1:0]  pe_wr;
  logic [1:0]  es_wr;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic        aw_full;
  logic        w_full;
  logic        next_aw_full;
  logic        next_w_full;
  logic        next_rvalid;
  logic        wr_fire;
  logic        wr_hit;
  logic        rd_hit;
  logic [13:0] wr_idx;
  logic [13:0] rd_idx;
  logic [15:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [31:0] rd_word;

  assign pins[0] = key_input_pins_0;
  assign pins[1] = key_input_pins_1;

  // Mask of enabled inputs that sit at their asserted level
  function automatic logic [7:0] asserted_vec(input logic [7:0] v, input logic [7:0] es,
                                              input logic [7:0] pe);
    return ((v & es) | (~v & ~es)) & pe;
  endfunction : asserted_vec

  // No debug-halt input: detection never pauses in background debug
  always_comb begin
    for (int i = 0; i < keypad_pin_interrupt_pkg::UNITS; i++) begin
      asrt[i] = asserted_vec(pins[i], u[i].polarity_select_bits, u[i].pin_enable_bits);
      // Previous sample deasserted and current asserted forms an edge
      edge_hit[i] = |(asrt[i] & ~asserted_vec(prev[i], u[i].polarity_select_bits,
                                              u[i].pin_enable_bits));
      det[i] = (armed[i] & edge_hit[i]) | (u[i].detect_mode_select & |asrt[i]);
    end
  end

  // Input history and re-arm after all enabled inputs go idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev[0] <= keypad_pin_interrupt_pkg::REG8_RESET;
      prev[1] <= keypad_pin_interrupt_pkg::REG8_RESET;
      armed   <= 2'h3;
    end else if (ce) begin
      for (int i = 0; i < keypad_pin_interrupt_pkg::UNITS; i++) begin
        prev[i] <= pins[i];
        if (armed[i] && edge_hit[i]) begin
          armed[i] <= 1'b0;
        end else if (!(|asrt[i])) begin
          armed[i] <= 1'b1;
        end
      end
    end
  end

  // Write channel bookkeeping: address and data may come in either order
  assign wr_fire      = aw_full & w_full & ~s_axi_bvalid;
  assign next_aw_full = wr_fire ? 1'b0 : (aw_full | (s_axi_awvalid & s_axi_awready));
  assign next_w_full  = wr_fire ? 1'b0 : (w_full | (s_axi_wvalid & s_axi_wready));
  assign wr_idx       = awaddr_q[15:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= keypad_pin_interrupt_pkg::RESP_OKAY;
      awaddr_q      <= 16'h0000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else if (ce) begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      s_axi_awready <= ~next_aw_full;
      s_axi_wready  <= ~next_w_full;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? keypad_pin_interrupt_pkg::RESP_OKAY
                               : keypad_pin_interrupt_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Address decode; only byte lane 0 carries register data
  always_comb begin
    sc_wr  = 2'h0;
    pe_wr  = 2'h0;
    es_wr  = 2'h0;
    wr_hit = 1'b1;
    unique case (wr_idx)
      keypad_pin_interrupt_pkg::IDX_SC_0:     sc_wr[0] = wr_fire & wstrb_q[0];
      keypad_pin_interrupt_pkg::IDX_SC_1:     sc_wr[1] = wr_fire & wstrb_q[0];
      keypad_pin_interrupt_pkg::IDX_PE_0:     pe_wr[0] = wr_fire & wstrb_q[0];
      keypad_pin_interrupt_pkg::IDX_ES_0:     es_wr[0] = wr_fire & wstrb_q[0];
      keypad_pin_interrupt_pkg::IDX_PE_1:     pe_wr[1] = wr_fire & wstrb_q[0];
      keypad_pin_interrupt_pkg::IDX_ES_1:     es_wr[1] = wr_fire & wstrb_q[0];
      keypad_pin_interrupt_pkg::IDX_IRQ_STAT: wr_hit   = 1'b1;
      keypad_pin_interrupt_pkg::IDX_IRQ_MASK: wr_hit   = 1'b1;
      default:                                wr_hit   = 1'b0;
    endcase
  end

  // Unit registers and the event flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      u[0] <= keypad_pin_interrupt_pkg::UNIT_RESET;
      u[1] <= keypad_pin_interrupt_pkg::UNIT_RESET;
    end else if (ce) begin
      for (int i = 0; i < keypad_pin_interrupt_pkg::UNITS; i++) begin
        if (pe_wr[i]) begin
          u[i].pin_enable_bits <= wdata_q[7:0];
        end
        if (es_wr[i]) begin
          u[i].polarity_select_bits <= wdata_q[7:0];
        end
        if (sc_wr[i]) begin
          u[i].irq_enable         <= wdata_q[keypad_pin_interrupt_pkg::SC_IE_BIT];
          u[i].detect_mode_select <= wdata_q[keypad_pin_interrupt_pkg::SC_MODE_BIT];
        end
        // Written flag bit is never looked at
        if (det[i]) begin
          u[i].key_event_flag <= 1'b1;
        end else if (sc_wr[i] && wdata_q[keypad_pin_interrupt_pkg::SC_ACK_BIT]
                     && !(|asrt[i])) begin
          u[i].key_event_flag <= 1'b0;
        end
      end
    end
  end

  // Request per unit doubles as the wait and stop3 wake level; stop3 needs aclk running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request <= keypad_pin_interrupt_pkg::IRQ2_RESET;
    end else if (ce) begin
      irq_request[0] <= u[0].key_event_flag & u[0].irq_enable;
      irq_request[1] <= u[1].key_event_flag & u[1].irq_enable;
    end
  end

  // Sticky summary status, write one to clear, a new set beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= keypad_pin_interrupt_pkg::IRQ2_RESET;
      irq_mask <= keypad_pin_interrupt_pkg::IRQ2_RESET;
      irq      <= 1'b0;
    end else if (ce) begin
      for (int i = 0; i < keypad_pin_interrupt_pkg::UNITS; i++) begin
        if (det[i] && !u[i].key_event_flag) begin
          irq_stat[i] <= 1'b1;
        end else if (wr_fire && wstrb_q[0] && wdata_q[i]
                     && wr_idx == keypad_pin_interrupt_pkg::IDX_IRQ_STAT) begin
          irq_stat[i] <= 1'b0;
        end
      end
      if (wr_fire && wstrb_q[0] && wr_idx == keypad_pin_interrupt_pkg::IDX_IRQ_MASK) begin
        irq_mask <= wdata_q[1:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // Read path; upper status nibble is hard zero
  assign rd_idx = s_axi_araddr[15:2];
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (rd_idx)
      keypad_pin_interrupt_pkg::IDX_SC_0:
        rd_word[3:0] = {u[0].key_event_flag, 1'b0, u[0].irq_enable, u[0].detect_mode_select};
      keypad_pin_interrupt_pkg::IDX_SC_1:
        rd_word[3:0] = {u[1].key_event_flag, 1'b0, u[1].irq_enable, u[1].detect_mode_select};
      keypad_pin_interrupt_pkg::IDX_PE_0:     rd_word[7:0] = u[0].pin_enable_bits;
      keypad_pin_interrupt_pkg::IDX_ES_0:     rd_word[7:0] = u[0].polarity_select_bits;
      keypad_pin_interrupt_pkg::IDX_PE_1:     rd_word[7:0] = u[1].pin_enable_bits;
      keypad_pin_interrupt_pkg::IDX_ES_1:     rd_word[7:0] = u[1].polarity_select_bits;
      keypad_pin_interrupt_pkg::IDX_IRQ_STAT: rd_word[1:0] = irq_stat;
      keypad_pin_interrupt_pkg::IDX_IRQ_MASK: rd_word[1:0] = irq_mask;
      default:                                rd_hit       = 1'b0;
    endcase
  end

  assign next_rvalid = s_axi_rvalid ? ~s_axi_rready : (s_axi_arvalid & s_axi_arready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= keypad_pin_interrupt_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? keypad_pin_interrupt_pkg::RESP_OKAY
                              : keypad_pin_interrupt_pkg::RESP_SLVERR;
      end
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sc_read_upper_zero;
    (ce && s_axi_arvalid && s_axi_arready
     && (rd_idx == keypad_pin_interrupt_pkg::IDX_SC_0
         || rd_idx == keypad_pin_interrupt_pkg::IDX_SC_1)) |=> (s_axi_rdata[7:4] == 4'h0);
  endproperty
  a_sc_read_upper_zero: assert property (p_sc_read_upper_zero)
    else $error("status upper nibble read nonzero");

  property p_flag_write_ignored;
    (ce && sc_wr[0] && wdata_q[keypad_pin_interrupt_pkg::SC_FLAG_BIT] && !det[0]
     && !u[0].key_event_flag) |=> !u[0].key_event_flag;
  endproperty
  a_flag_write_ignored: assert property (p_flag_write_ignored)
    else $error("flag set by software write");

  property p_ack_clears;
    (ce && sc_wr[0] && wdata_q[keypad_pin_interrupt_pkg::SC_ACK_BIT] && !(|asrt[0])
     && !det[0]) |=> !u[0].key_event_flag;
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("acknowledge did not clear flag");

  property p_ack_blocked;
    (ce && sc_wr[0] && (|asrt[0]) && u[0].key_event_flag) |=> u[0].key_event_flag;
  endproperty
  a_ack_blocked: assert property (p_ack_blocked)
    else $error("flag cleared while input asserted");

  property p_detect_sets;
    (ce && det[1]) |=> u[1].key_event_flag;
  endproperty
  a_detect_sets: assert property (p_detect_sets)
    else $error("detection lost");

  property p_request_follows;
    (ce && u[0].key_event_flag && u[0].irq_enable) |=> irq_request[0] ##0 (!ce || $past(ce));
  endproperty
  a_request_follows: assert property (p_request_follows)
    else $error("request missing for enabled flag");

  property p_level_mode;
    (ce && u[0].detect_mode_select && (|asrt[0])) |=> u[0].key_event_flag;
  endproperty
  a_level_mode: assert property (p_level_mode)
    else $error("level not detected in level mode");

  property p_disabled_ignored;
    (u[1].pin_enable_bits == 8'h00) |-> !det[1];
  endproperty
  a_disabled_ignored: assert property (p_disabled_ignored)
    else $error("detection with no pin enabled");

  property p_falling_edge;
    (armed[0] && u[0].pin_enable_bits[0] && !u[0].polarity_select_bits[0]
     && prev[0][0] && !pins[0][0]) |-> det[0];
  endproperty
  a_falling_edge: assert property (p_falling_edge)
    else $error("falling edge missed");

  property p_rising_edge;
    (armed[1] && u[1].pin_enable_bits[7] && u[1].polarity_select_bits[7]
     && !prev[1][7] && pins[1][7]) |-> det[1];
  endproperty
  a_rising_edge: assert property (p_rising_edge)
    else $error("rising edge missed");

  property p_no_rearm_edge;
    (!armed[0] && !u[0].detect_mode_select) |-> !det[0];
  endproperty
  a_no_rearm_edge: assert property (p_no_rearm_edge)
    else $error("edge detected before re-arm");

  property p_reset_zero;
    !$past(aresetn) |-> (u[0] == keypad_pin_interrupt_pkg::UNIT_RESET
                         && u[1] == keypad_pin_interrupt_pkg::UNIT_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("registers not zero after reset");

endmodule : keypad_pin_interrupt

`default_nettype wire

// File: test/key_source_model.sv
// Behavioural model of the key switches or interrupt sources feeding one unit.
// Assumes the bench names which pins are asserted and the polarity each pin uses.
`timescale 1ns/1ps
`default_nettype none

module key_source_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] asserted,
  input  wire logic [7:0] polarity,
  output logic [7:0]      pins
);
  // Pins leave reset at their deasserted level, so detection can start clean
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins <= ~polarity;
    end else begin
      pins <= ~(asserted ^ polarity);
    end
  end
endmodule : key_source_model

`default_nettype wire

// File: test/keypad_pin_interrupt_test.sv
// Self-checking bench for the keypad pin interrupt block over AXI4-Lite.
// Assumes one 100 MHz clock and key inputs synchronous to it; ce is held high.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("Error at %0t ns: got 0x%0h expected 0x%0h", $time, (got), (exp)); end end

module keypad_pin_interrupt_test;
  localparam logic [15:0] A_SC0  = {keypad_pin_interrupt_pkg::IDX_SC_0, 2'b00};
  localparam logic [15:0] A_SC1  = {keypad_pin_interrupt_pkg::IDX_SC_1, 2'b00};
  localparam logic [15:0] A_PE0  = {keypad_pin_interrupt_pkg::IDX_PE_0, 2'b00};
  localparam logic [15:0] A_ES0  = {keypad_pin_interrupt_pkg::IDX_ES_0, 2'b00};
  localparam logic [15:0] A_PE1  = {keypad_pin_interrupt_pkg::IDX_PE_1, 2'b00};
  localparam logic [15:0] A_ES1  = {keypad_pin_interrupt_pkg::IDX_ES_1, 2'b00};
  localparam logic [15:0] A_STAT = {keypad_pin_interrupt_pkg::IDX_IRQ_STAT, 2'b00};
  localparam logic [15:0] A_MASK = {keypad_pin_interrupt_pkg::IDX_IRQ_MASK, 2'b00};

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [15:0] awaddr = '0;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = '0;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [15:0] araddr = '0;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic [7:0]  pins_0;
  logic [7:0]  pins_1;
  logic [7:0]  hold_0 = '0;
  logic [7:0]  hold_1 = '0;
  logic [7:0]  pol_1 = 8'h80;
  logic [1:0]  irq_request;
  logic        irq;
  logic [1:0]  last_resp;
  logic [7:0]  rd;
  int          miscompares = 0;
  int          samples_checked = 0;

  always #5 aclk = ~aclk;

  key_source_model i_keys_0 (.aclk(aclk), .aresetn(aresetn), .asserted(hold_0),
                             .polarity(8'h00), .pins(pins_0));
  key_source_model i_keys_1 (.aclk(aclk), .aresetn(aresetn), .asserted(hold_1),
                             .polarity(pol_1), .pins(pins_1));

  keypad_pin_interrupt i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .key_input_pins_0(pins_0), .key_input_pins_1(pins_1),
    .irq_request(irq_request), .irq(irq)
  );

  // Called just after a rising edge; returns one edge after the response is taken,
  // so a following call never re-raises bready or rready in the same time step
  task automatic axi_write(input logic [15:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    last_resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write

  // A hung slave is caught by the watchdog, not by a local limit
  task automatic axi_read(input logic [15:0] a, output logic [7:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata[7:0];
    last_resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // Generous bound: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_read(A_SC0, rd);  `CHK(rd, 8'h00)
    axi_read(A_SC1, rd);  `CHK(rd, 8'h00)
    axi_read(A_PE0, rd);  `CHK(rd, 8'h00)
    axi_read(A_ES0, rd);  `CHK(rd, 8'h00)
    axi_read(A_PE1, rd);  `CHK(rd, 8'h00)
    axi_read(A_ES1, rd);  `CHK(rd, 8'h00)
    $display("Test reset values done");
    // Reserved bits, flag and acknowledge must not read back what was written
    axi_write(A_SC0, 8'hff);
    axi_read(A_SC0, rd);  `CHK(rd, 8'h03)
    axi_write(A_SC0, 8'h00);
    $display("Test status bits done");
    axi_write(A_ES0, 8'h00);
    axi_write(A_PE0, 8'h01);
    axi_write(A_SC0, 8'h02);
    hold_0 <= 8'h02;
    repeat (4) @(posedge aclk);
    axi_read(A_SC0, rd);  `CHK(rd, 8'h02)
    hold_0 <= 8'h01;
    repeat (4) @(posedge aclk);
    axi_read(A_SC0, rd);  `CHK(rd, 8'h0a)
    `CHK(irq_request[0], 1'b1)
    axi_write(A_SC0, 8'h06);
    axi_read(A_SC0, rd);  `CHK(rd, 8'h0a)
    hold_0 <= 8'h00;
    repeat (4) @(posedge aclk);
    axi_write(A_SC0, 8'h06);
    axi_read(A_SC0, rd);  `CHK(rd, 8'h02)
    `CHK(irq_request[0], 1'b0)
    $display("Test falling edge done");
    // A pin already asserted when enabled is no edge, but counts as a level
    axi_write(A_PE0, 8'h00);
    hold_0 <= 8'h10;
    repeat (4) @(posedge aclk);
    axi_write(A_PE0, 8'h10);
    repeat (4) @(posedge aclk);
    axi_read(A_SC0, rd);  `CHK(rd, 8'h02)
    axi_write(A_SC0, 8'h03);
    repeat (4) @(posedge aclk);
    axi_read(A_SC0, rd);  `CHK(rd, 8'h0b)
    hold_0 <= 8'h00;
    repeat (4) @(posedge aclk);
    axi_write(A_SC0, 8'h04);
    axi_read(A_SC0, rd);  `CHK(rd, 8'h00)
    $display("Test level mode done");
    axi_write(A_STAT, 8'h03);
    axi_write(A_ES1, 8'h80);
    axi_write(A_PE1, 8'h80);
    axi_write(A_SC1, 8'h02);
    hold_1 <= 8'h80;
    repeat (4) @(posedge aclk);
    axi_read(A_SC1, rd);  `CHK(rd, 8'h0a)
    `CHK(irq_request[1], 1'b1)
    axi_read(A_STAT, rd); `CHK(rd, 8'h02)
    `CHK(irq, 1'b0)
    axi_write(A_MASK, 8'h02);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    axi_write(A_STAT, 8'h02);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    axi_write(A_SC1, 8'h00);
    repeat (2) @(posedge aclk);
    `CHK(irq_request[1], 1'b0)
    $display("Test rising edge and interrupt done");
    axi_write(16'h0100, 8'h55);
    `CHK(last_resp, keypad_pin_interrupt_pkg::RESP_SLVERR)
    axi_read(16'h0100, rd);
    `CHK(last_resp, keypad_pin_interrupt_pkg::RESP_SLVERR)
    `CHK(rd, 8'h00)
    $display("Test unmapped access done");
    print_verdict();
  end
endmodule : keypad_pin_interrupt_test

`default_nettype wire
